// ==== gpio_port_defines.svh ====
`ifndef GPIO_PORT_DEFINES_SVH
`define GPIO_PORT_DEFINES_SVH

// ==========================================================================
// Register bus geometry
`define ADDR_W 8
`define DATA_W 8

// ==========================================================================
// Register offsets, one byte lane per port, four ports
`define OFS_DATA_BASE 8'h00
`define OFS_MODE_HI_BASE 8'h04
`define OFS_MODE_LO_BASE 8'h08
`define OFS_AIN_DIS 8'h0C
`define OFS_DRIVE_BASE 8'h10
`define OFS_STRONG_BASE 8'h14

// ==========================================================================
// Port geometry
`define NUM_PORTS 4
`define PORT_W 8
`define NUM_PINS 26
`define PORT3_MASK 8'h03
`define FULL_MASK 8'hFF

// ==========================================================================
// Reset values
`define LATCH_RST 8'hFF
`define MODE_HI_RST 8'hFF
`define MODE_LO_RST 8'h00
`define AIN_DIS_RST 8'h00
`define AIN_DIS_MASK 8'h3E

// ==========================================================================
// Pins with restricted configuration (flat index = port * 8 + bit)
`define PIN_RST_IDX 13
`define PIN_SCL_IDX 10
`define PIN_SDA_IDX 11

// ==========================================================================
// Strong pull-up pulse length in CPU clocks
`define STRONG_PU_CLKS 2
`define STRONG_CNT_W 2

`endif

// ==== gpio_port_pkg.sv ====
package gpio_port_pkg;

  // ========================================================================
  // Output mode, {select high, select low}
  typedef enum logic [1:0] {
    MODE_QUASI = 2'h0,
    MODE_PUSH_PULL = 2'h1,
    MODE_INPUT_ONLY = 2'h2,
    MODE_OPEN_DRAIN = 2'h3
  } pin_mode_e;

endpackage

// ==== sync2.sv ====
`timescale 1ns/1ps

module sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // ========================================================================
  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;

endmodule

// ==== pin_ctrl.sv ====
`timescale 1ns/1ps
`include "gpio_port_defines.svh"

module pin_ctrl #(
  parameter int STRONG_CLKS = `STRONG_PU_CLKS,
  parameter int CNT_W = `STRONG_CNT_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Configuration and state
  input wire logic [1:0] mode,
  input wire logic latch,
  input wire logic pin_lvl,
  // Pull controls
  output logic pd_en,
  output logic pu_strong_en,
  output logic pu_weak_en,
  output logic pu_vweak_en
);

  logic latch_q_r;
  logic [CNT_W-1:0] cnt_r;
  logic quasi;
  logic push_pull;
  logic rise;

  // Mode decode
  assign quasi = (mode == gpio_port_pkg::MODE_QUASI); // [R1]
  assign push_pull = (mode == gpio_port_pkg::MODE_PUSH_PULL); // [R1]
  assign rise = latch & ~latch_q_r;

  // ========================================================================
  // Latch history for 0 to 1 detection
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      latch_q_r <= 1'b1;
    end else begin
      latch_q_r <= latch;
    end
  end

  // Remaining cycles of the strong pull-up pulse after the rising cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (!quasi || !latch) begin
      cnt_r <= '0;
    end else if (rise) begin
      cnt_r <= CNT_W'(STRONG_CLKS - 1); // [R7]
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  // ========================================================================
  // Pull-down is shared by every driving mode
  assign pd_en = ~latch & (mode != gpio_port_pkg::MODE_INPUT_ONLY); // [R4] [R8] [R9]
  // Strong pull-up: timed in quasi mode, steady in push-pull
  assign pu_strong_en = latch & ((quasi & (rise | (cnt_r != '0))) // [R7]
                        | push_pull); // [R9]
  // Weak pull-up follows the sensed level
  assign pu_weak_en = quasi & latch & pin_lvl; // [R6]
  // Very weak pull-up follows the latch only
  assign pu_vweak_en = quasi & latch; // [R4] [R5]

endmodule

// ==== gpio_port_mode_config.sv ====
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "gpio_port_defines.svh"

// Function
// R1 - Two mode bits per pin: quasi, push-pull, input-only, open drain.
// R2 - Reset-shared pin is always input; its mode bits are ignored.
// R3 - Two-wire clock and data pins: only input-only or open drain.
// R4 - Quasi mode: latch 0 drives strong low, latch 1 pulls weakly high.
// R5 - Quasi mode: very weak pull-up on whenever latch holds 1.
// R6 - Quasi mode: weak pull-up on only when latch and pin are 1.
// R7 - Quasi mode: latch 0 to 1 gives strong pull-up for two clocks.
// R8 - Open drain: no pull-ups; pull-down only while latch holds 0.
// R9 - Push-pull: same pull-down; strong pull-up steady while latch is 1.
// R10 - Port 0 analog disable bits 1 to 5 turn off digital inputs.
// R11 - Reads of a port bit with disabled input return 0.
// R12 - Analog disable bits clear to 0 on every reset.
// R13 - After power-up every pin sits in input-only mode.
// R14 - Software sets input-only and disable bit for analog pins.
// R15 - Enabled inputs read the synchronised pin level in every mode.

module gpio_port_mode_config (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [`ADDR_W-1:0] reg_addr,
  input wire logic [`DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`DATA_W-1:0] reg_rdata,
  // Pads
  input wire logic [`NUM_PINS-1:0] pad_i,
  output logic [`NUM_PINS-1:0] pad_o,
  output logic [`NUM_PINS-1:0] pad_oe,
  // Pull controls per pin
  output logic [`NUM_PINS-1:0] pd_en,
  output logic [`NUM_PINS-1:0] pu_strong_en,
  output logic [`NUM_PINS-1:0] pu_weak_en,
  output logic [`NUM_PINS-1:0] pu_vweak_en,
  // Digital input enable per pin
  output logic [`NUM_PINS-1:0] din_en
);

  // ========================================================================
  // Storage
  logic [`PORT_W-1:0] latch_r [`NUM_PORTS];
  logic [`PORT_W-1:0] pin_mode_select_high_r [`NUM_PORTS];
  logic [`PORT_W-1:0] pin_mode_select_low_r [`NUM_PORTS];
  logic [`PORT_W-1:0] port0_analog_input_disable_r;
  logic [`DATA_W-1:0] rdata_r;
  logic [`DATA_W-1:0] rdata_nxt;

  // Flattened per-pin views
  logic [`NUM_PINS-1:0] latch_flat;
  logic [`NUM_PINS-1:0] pin_sync;
  logic [`NUM_PINS-1:0] pin_read;
  logic [1:0] eff_mode [`NUM_PINS];
  // Pad drive split by level
  logic [`NUM_PINS-1:0] drive_low;
  logic [`NUM_PINS-1:0] drive_high;

  // Register decode and write enables
  logic [`NUM_PORTS-1:0] data_hit;
  logic [`NUM_PORTS-1:0] mode_hi_hit;
  logic [`NUM_PORTS-1:0] mode_lo_hit;
  logic [`NUM_PORTS-1:0] drive_hit;
  logic [`NUM_PORTS-1:0] strong_hit;
  logic ain_hit;
  logic [`NUM_PORTS-1:0] data_we;
  logic [`NUM_PORTS-1:0] mode_hi_we;
  logic [`NUM_PORTS-1:0] mode_lo_we;
  logic ain_we;

  // Per-port read views
  logic [`PORT_W-1:0] port_in [`NUM_PORTS];
  logic [`PORT_W-1:0] port_drive [`NUM_PORTS];
  logic [`PORT_W-1:0] port_strong [`NUM_PORTS];

  // ========================================================================
  // Helper functions

  // Bits that exist in a port
  function automatic logic [`PORT_W-1:0] port_mask(input int p);
    logic [`PORT_W-1:0] m;
    m = `FULL_MASK;
    if (p == `NUM_PORTS - 1) begin
      m = `PORT3_MASK;
    end
    return m;
  endfunction

  // Address match against one register of a per-port bank
  function automatic logic bank_hit(input logic [`ADDR_W-1:0] addr,
                                    input logic [`ADDR_W-1:0] base,
                                    input int p);
    return addr == (base + `ADDR_W'(p));
  endfunction

  // Mode seen by the pin logic after pin restrictions
  function automatic logic [1:0] restrict_mode(input int idx,
                                               input logic hi,
                                               input logic lo);
    logic [1:0] m;
    m = {hi, lo};
    if (idx == `PIN_RST_IDX) begin
      m = gpio_port_pkg::MODE_INPUT_ONLY; // [R2]
    end else if (idx == `PIN_SCL_IDX || idx == `PIN_SDA_IDX) begin
      m = {1'b1, lo}; // [R3]
    end
    return m;
  endfunction

  // Gather one port's bits from a flat pin vector
  function automatic logic [`PORT_W-1:0] port_bits(
      input logic [`NUM_PINS-1:0] v, input int p);
    logic [`PORT_W-1:0] b;
    b = '0;
    for (int i = 0; i < `PORT_W; i++) begin
      if (p * `PORT_W + i < `NUM_PINS) begin
        b[i] = v[p * `PORT_W + i];
      end
    end
    return b;
  endfunction

  // ========================================================================
  // Address decode; each bank holds one register per port
  for (genvar p = 0; p < `NUM_PORTS; p++) begin : g_dec
    assign data_hit[p] = bank_hit(reg_addr, `OFS_DATA_BASE, p);
    assign mode_hi_hit[p] = bank_hit(reg_addr, `OFS_MODE_HI_BASE, p);
    assign mode_lo_hit[p] = bank_hit(reg_addr, `OFS_MODE_LO_BASE, p);
    assign drive_hit[p] = bank_hit(reg_addr, `OFS_DRIVE_BASE, p);
    assign strong_hit[p] = bank_hit(reg_addr, `OFS_STRONG_BASE, p);
  end
  // Single register outside the banks
  assign ain_hit = (reg_addr == `OFS_AIN_DIS);

  // Write enables; a strobe only lands on the register it addresses
  assign data_we = data_hit & {`NUM_PORTS{reg_wr}};
  assign mode_hi_we = mode_hi_hit & {`NUM_PORTS{reg_wr}};
  assign mode_lo_we = mode_lo_hit & {`NUM_PORTS{reg_wr}};
  assign ain_we = ain_hit & reg_wr;

  // ========================================================================
  // Output latches, written by software
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < `NUM_PORTS; p++) begin
        latch_r[p] <= `LATCH_RST & port_mask(p);
      end
    end else begin
      for (int p = 0; p < `NUM_PORTS; p++) begin
        if (data_we[p]) begin
          latch_r[p] <= reg_wdata & port_mask(p);
        end
      end
    end
  end

  // Mode select high bits; power-up leaves every pin input-only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < `NUM_PORTS; p++) begin
        pin_mode_select_high_r[p] <= `MODE_HI_RST & port_mask(p); // [R13]
      end
    end else begin
      for (int p = 0; p < `NUM_PORTS; p++) begin
        if (mode_hi_we[p]) begin
          pin_mode_select_high_r[p] <= reg_wdata & port_mask(p);
        end
      end
    end
  end

  // Mode select low bits
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < `NUM_PORTS; p++) begin
        pin_mode_select_low_r[p] <= `MODE_LO_RST; // [R13]
      end
    end else begin
      for (int p = 0; p < `NUM_PORTS; p++) begin
        if (mode_lo_we[p]) begin
          pin_mode_select_low_r[p] <= reg_wdata & port_mask(p);
        end
      end
    end
  end

  // Port 0 digital input disable, bits 1 to 5 only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      port0_analog_input_disable_r <= `AIN_DIS_RST; // [R12]
    end else if (ain_we) begin
      port0_analog_input_disable_r <= reg_wdata & `AIN_DIS_MASK; // [R10]
    end
  end

  // ========================================================================
  // Pad input synchroniser
  sync2 #(
    .WIDTH(`NUM_PINS)
  ) u_pad_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d(pad_i),
    .q(pin_sync)
  );

  // ========================================================================
  // Per-pin mode decode and pull control
  for (genvar i = 0; i < `NUM_PINS; i++) begin : g_pin
    localparam int P = i / `PORT_W;
    localparam int B = i % `PORT_W;

    // Latch and effective mode of this pin
    assign latch_flat[i] = latch_r[P][B];
    assign eff_mode[i] = restrict_mode(i, pin_mode_select_high_r[P][B],
                                       pin_mode_select_low_r[P][B]);

    // Pull controls of this pin
    pin_ctrl u_pin (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .mode(eff_mode[i]),
      .latch(latch_flat[i]),
      .pin_lvl(pin_sync[i]),
      .pd_en(pd_en[i]),
      .pu_strong_en(pu_strong_en[i]),
      .pu_weak_en(pu_weak_en[i]),
      .pu_vweak_en(pu_vweak_en[i])
    );

    // Digital input gate; only port 0 bits 1 to 5 can be disabled
    if (P == 0) begin : g_ain
      assign din_en[i] = ~port0_analog_input_disable_r[B]; // [R10]
    end else begin : g_dig
      assign din_en[i] = 1'b1;
    end

    // Read value of this pin
    assign pin_read[i] = pin_sync[i] & din_en[i]; // [R11] [R15]
  end

  // ========================================================================
  // Pad drive: low through the pull-down, high through the strong pull-up
  assign drive_low = pd_en; // [R8] [R9]
  assign drive_high = pu_strong_en & ~pd_en;
  // Weak pull-ups are not a drive, so they never raise the enable
  assign pad_oe = drive_low | drive_high; // [R3] [R8]
  // Driven level; meaningful only while the enable is high
  assign pad_o = drive_high;

  // ========================================================================
  // Per-port views for the read multiplexer
  for (genvar p = 0; p < `NUM_PORTS; p++) begin : g_view
    assign port_in[p] = port_bits(pin_read, p); // [R11] [R15]
    assign port_drive[p] = port_bits(pad_oe, p);
    assign port_strong[p] = port_bits(pu_strong_en, p);
  end

  // ========================================================================
  // Read multiplexer; unmapped addresses read 0
  always_comb begin
    rdata_nxt = '0;
    for (int p = 0; p < `NUM_PORTS; p++) begin
      if (data_hit[p]) begin
        rdata_nxt = port_in[p]; // [R11] [R15]
      end
      if (mode_hi_hit[p]) begin
        rdata_nxt = pin_mode_select_high_r[p];
      end
      if (mode_lo_hit[p]) begin
        rdata_nxt = pin_mode_select_low_r[p];
      end
      if (drive_hit[p]) begin
        rdata_nxt = port_drive[p];
      end
      if (strong_hit[p]) begin
        rdata_nxt = port_strong[p];
      end
    end
    // Disable register sits outside the banks
    if (ain_hit) begin
      rdata_nxt = port0_analog_input_disable_r;
    end
  end

  // Read data valid only in the cycle after the read strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
    end else if (reg_rd) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= '0;
    end
  end

  // Read data leaves straight from the flop
  assign reg_rdata = rdata_r;

endmodule

// ==== pad_model.sv ====
`timescale 1ns/1ps

module pad_model (
  // Pull controls from the port
  input wire logic [25:0] pd_en,
  input wire logic [25:0] pu_strong_en,
  input wire logic [25:0] pu_weak_en,
  input wire logic [25:0] pu_vweak_en,
  // Outside devices: sink low or pull up
  input wire logic [25:0] ext_low,
  input wire logic [25:0] ext_hi,
  // Resolved pin level
  output logic [25:0] pad_i
);
  // =====
  // Pin level
  // Strong drive wins, an outside sink beats the weak pulls
  assign pad_i = ~pd_en & (pu_strong_en |
    ~ext_low & (pu_weak_en | pu_vweak_en | ext_hi));
endmodule

// ==== gpio_port_mode_config_sva.sv ====
`timescale 1ns/1ps

module gpio_port_mode_config_sva (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Watched ports
  input wire logic reg_rd,
  input wire logic [25:0] pad_i,
  input wire logic [25:0] pad_o,
  input wire logic [25:0] pad_oe,
  input wire logic [25:0] pd_en,
  input wire logic [25:0] pu_strong_en,
  input wire logic [25:0] pu_weak_en,
  input wire logic [25:0] pu_vweak_en,
  input wire logic [25:0] din_en
);
  // =====
  // Pull relations
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_rst;
    !(pd_en[13] | pad_oe[13] | pu_vweak_en[13] | pu_weak_en[13]);
  endproperty
  a_rst: assert property (p_rst) else $error("reset pin drives");
  property p_twi;
    (pu_strong_en[11:10] | pu_vweak_en[11:10]) == 2'h0;
  endproperty
  a_twi: assert property (p_twi) else $error("two-wire pin up");
  property p_wvw;
    (pu_weak_en & ~pu_vweak_en) == 26'h0;
  endproperty
  a_wvw: assert property (p_wvw) else $error("weak without vweak");
  property p_wpad;
    (pu_weak_en & ~pad_i & ~$past(pad_i) & ~$past(pad_i, 2)
      & ~$past(pad_i, 3)) == 26'h0;
  endproperty
  a_wpad: assert property (p_wpad) else $error("weak on low pin");
  property p_fight;
    (pd_en & (pu_strong_en | pu_weak_en | pu_vweak_en)) == 26'h0;
  endproperty
  a_fight: assert property (p_fight) else $error("pull fight");
  property p_pulse;
    $rose(pu_strong_en[16]) && pu_vweak_en[16] |=>
      pu_strong_en[16] ##1 !pu_strong_en[16];
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse length");
  property p_drv;
    (pad_oe & ~pad_o) == pd_en && (pad_oe & pad_o) == pu_strong_en;
  endproperty
  a_drv: assert property (p_drv) else $error("drive mismatch");
  property p_din;
    &{din_en[25:6], din_en[0]};
  endproperty
  a_din: assert property (p_din) else $error("input disabled");
  // Main scenarios seen
  c_pulse: cover property ($rose(pu_strong_en[16]) && pu_vweak_en[16]);
  c_weak: cover property (pu_weak_en[16]);
  c_read: cover property (reg_rd);
endmodule

bind gpio_port_mode_config gpio_port_mode_config_sva i_sva (.clk_sys,
  .rst_n, .reg_rd, .pad_i, .pad_o, .pad_oe, .pd_en, .pu_strong_en,
  .pu_weak_en, .pu_vweak_en, .din_en);

// ==== tb_gpio_port_mode_config.sv ====
`timescale 1ns/1ps

module tb_gpio_port_mode_config;
  // =====
  // Stimulus and results
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [7:0] reg_rdata;
  logic [25:0] pad_i, pad_o, pad_oe, pd_en, din_en;
  logic [25:0] pu_strong_en, pu_weak_en, pu_vweak_en;
  logic [25:0] ext_low = 26'h0;
  logic [25:0] ext_hi = 26'h0;
  logic [15:0] exp_q[$];
  logic [15:0] note;
  logic [31:0] v;
  logic [7:0] r, e;
  logic [1:0] mb;
  logic rd_d = 1'h0;
  int failures = 0;
  int comparisons = 0;

  always #10 clk_sys = ~clk_sys;

  gpio_port_mode_config i_gpio_port_mode_config (.clk_sys, .rst_n,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pad_i, .pad_o,
    .pad_oe, .pd_en, .pu_strong_en, .pu_weak_en, .pu_vweak_en, .din_en);
  pad_model i_pad_model (.pd_en, .pu_strong_en, .pu_weak_en, .pu_vweak_en,
    .ext_low, .ext_hi, .pad_i);

  // =====
  // Tasks
  task automatic check(input string n, input logic [25:0] x,
                       input logic [25:0] g);
    comparisons++;
    if (g !== x) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk_sys);
    reg_rd <= 1'h1;
    reg_addr <= a;
    exp_q.push_back({a, x});
    @(posedge clk_sys);
    reg_rd <= 1'h0;
  endtask

  task automatic summarize();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // =====
  // Read data monitor, one cycle after each read
  always @(posedge clk_sys) rd_d <= reg_rd;
  always @(negedge clk_sys) begin
    if (rd_d && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      check($sformatf("reg %h", note[15:8]), 26'(note[7:0]), 26'(reg_rdata));
    end
  end

  // Watchdog
  initial begin
    #200000;
    failures++;
    summarize();
  end

  // =====
  // Main sequence
  initial begin
    void'($urandom(32'h84C459B3));
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'h1;
    for (logic [7:0] p = 8'h00; p < 8'h04; p++) begin
      rd(8'h04 + p, (p == 8'h03) ? 8'h03 : 8'hFF);
      rd(8'h08 + p, 8'h00);
      rd(8'h10 + p, 8'h00);
    end
    rd(8'h0C, 8'h00);
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h00);
    // Random levels on input-only pins
    ext_hi <= 26'($urandom);
    repeat (4) @(posedge clk_sys);
    v = 32'(ext_hi);
    for (logic [7:0] p = 8'h00; p < 8'h04; p++) begin
      rd(p, 8'(v >> (8 * p)));
    end
    // Analog use of port 0 pins
    r = 8'($urandom);
    wr(8'h0C, r);
    rd(8'h0C, r & 8'h3E);
    rd(8'h00, v[7:0] & ~(r & 8'h3E));
    check("din_en", {20'hFFFFF, ~r[5:0] | 6'h01}, din_en);
    // Port 2 through every mode
    ext_hi <= 26'h3FFFFFF;
    for (int m = 0; m < 4; m++) begin
      mb = 2'(m);
      wr(8'h06, {8{mb[1]}});
      wr(8'h0A, {8{mb[0]}});
      wr(8'h02, 8'h00);
      rd(8'h12, (mb == 2'h2) ? 8'h00 : 8'hFF);
      wr(8'h02, 8'hFF);
      #1;
      check("strong", {8{~mb[1]}}, pu_strong_en[23:16]);
      check("pad_o", {8{~mb[1]}}, pad_o[23:16]);
      @(posedge clk_sys);
      #1;
      check("strong", {8{~mb[1]}}, pu_strong_en[23:16]);
      @(posedge clk_sys);
      #1;
      check("strong", {8{mb == 2'h1}}, pu_strong_en[23:16]);
      check("pad_o", {8{mb == 2'h1}}, pad_o[23:16]);
      repeat (3) @(posedge clk_sys);
      e = {8{mb == 2'h0}};
      check("weak", e, pu_weak_en[23:16]);
      check("very weak", e, pu_vweak_en[23:16]);
      rd(8'h12, {8{mb == 2'h1}});
      ext_low <= 26'h0010000;
      repeat (4) @(posedge clk_sys);
      check("weak", e & 8'hFE, pu_weak_en[23:16]);
      rd(8'h02, (mb == 2'h1) ? 8'hFF : 8'hFE);
      ext_low <= 26'h0;
    end
    // Restricted pins of port 1
    wr(8'h05, 8'h00);
    wr(8'h09, 8'hFF);
    wr(8'h01, 8'h00);
    rd(8'h11, 8'hDF);
    wr(8'h01, 8'hFF);
    repeat (3) @(posedge clk_sys);
    rd(8'h15, 8'hD3);
    rd(8'h09, 8'hFF);
    wr(8'h09, 8'h00);
    wr(8'h01, 8'h00);
    rd(8'h11, 8'hD3);
    // Second reset in mid-run
    @(posedge clk_sys);
    rst_n <= 1'h0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'h1;
    rd(8'h0C, 8'h00);
    rd(8'h05, 8'hFF);
    repeat (3) @(posedge clk_sys);
    summarize();
  end
endmodule
